// *** common/ebt_pkg.sv ***
// Purpose: constants and types shared by the 8-bit pwm/interval timer
// Assumes: byte-wide register port, one clock, synchronous reset
// Notes:   registers sit at their full byte addresses on the port
//
// Notes on behaviour
// - with the enable bit low the counter is held at zero, and setting it starts counting on the chosen count clock.
// - the clock select field picks the undivided clock, divide by 2, 4, 64, 1024 or the cascaded timer output; other codes are not allowed.
// - the mode field in bits 3..2 selects interval mode for 00 and pwm mode for 10; other codes are not allowed.
// - the output level bit in bit 1 sets the default level of the timer output, low for 0 and high for 1.
// - the output enable bit in bit 0 gates the timer output pin, off for 0 and on for 1.
// - the duty register marks where the output goes inactive and may be rewritten while running.
// - after enabling the counter is compared with the period first; a match clears it and raises the interrupt, and in pwm mode drives active and moves to duty.
// - a duty match drives the inactive level and moves back to period, without clearing the counter or pulsing the compare match interrupt.

package ebt_pkg;

  // register byte addresses
  localparam logic [15:0] EBT_ADDR_MODE   = 16'hff69;
  localparam logic [15:0] EBT_ADDR_PERIOD = 16'hff6a;
  localparam logic [15:0] EBT_ADDR_DUTY   = 16'hff6b;
  localparam logic [15:0] EBT_ADDR_STATUS = 16'hff6c;
  localparam logic [15:0] EBT_ADDR_MASK   = 16'hff6d;
  localparam logic [15:0] EBT_ADDR_COUNT  = 16'hff6e;

  // reset values
  localparam logic [7:0] EBT_MODE_RST   = 8'h00;
  localparam logic [7:0] EBT_PERIOD_RST = 8'h00;
  localparam logic [7:0] EBT_DUTY_RST   = 8'h00;
  localparam logic [1:0] EBT_MASK_RST   = 2'h0;

  // status and mask bit positions
  localparam int EBT_STAT_PERIOD = 0;
  localparam int EBT_STAT_DUTY   = 1;
  localparam int EBT_STAT_W      = 2;

  // clock select codes
  localparam logic [2:0] EBT_CKS_DIV1    = 3'h0;
  localparam logic [2:0] EBT_CKS_DIV2    = 3'h1;
  localparam logic [2:0] EBT_CKS_DIV4    = 3'h2;
  localparam logic [2:0] EBT_CKS_DIV64   = 3'h3;
  localparam logic [2:0] EBT_CKS_DIV1024 = 3'h4;
  localparam logic [2:0] EBT_CKS_CASCADE = 3'h5;

  // prescaler width and terminal masks for each division
  localparam int          EBT_DIV_W       = 10;
  localparam logic [9:0]  EBT_MASK_DIV2   = 10'h001;
  localparam logic [9:0]  EBT_MASK_DIV4   = 10'h003;
  localparam logic [9:0]  EBT_MASK_DIV64  = 10'h03f;
  localparam logic [9:0]  EBT_MASK_DIV1K  = 10'h3ff;

  // operating mode codes
  localparam logic [1:0] EBT_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] EBT_MODE_PWM      = 2'h2;

  // mode control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       count_enable_bit;
    logic [2:0] clock_select;
    logic [1:0] operating_mode;
    logic       default_output_level;
    logic       output_pin_enable;
  } ebt_mode_s;

  // which compare register the counter is checked against
  typedef enum logic [1:0] {
    EBT_CMP_PERIOD = 2'b01,
    EBT_CMP_DUTY   = 2'b10
  } ebt_cmp_e;

  // timer core state
  typedef struct packed {
    ebt_mode_s  mode;
    logic [7:0] period;
    logic [7:0] duty;
    logic [1:0] mask;
    logic [7:0] count;
    ebt_cmp_e   cmp_sel;
    logic       active;
    logic       pin;
    logic       oe;
    logic       pulse;
    logic       irq;
    logic [7:0] rd_data;
  } ebt_core_s;

  // prescaler state
  typedef struct packed {
    logic [9:0] div;
    logic       casc_d;
    logic       tick;
  } ebt_presc_s;

endpackage : ebt_pkg

// *** rtl/ebt_sticky.sv ***
// Purpose: one sticky event flag, set by hardware, cleared by software
// Assumes: set and clear may land in the same cycle
// Notes:   set wins so an event is never lost on a clear
`timescale 1ns/1ps

module ebt_sticky (
  // clock and control
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // flag access
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);

  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = set_in | (flag_reg & ~clr_in);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_reg <= 1'b0;
    end else if (ce_in) begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

endmodule : ebt_sticky

// *** rtl/ebt_prescaler.sv ***
// Purpose: count clock source for the timer core
// Assumes: cascade input is synchronous to clk_in
// Notes:   tick is registered; one cycle long except on the undivided clock, where it stays high
`timescale 1ns/1ps

module ebt_prescaler (
  // clock and control
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // selection
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  input  wire logic       cascade_in,
  // count clock
  output logic            tick_out
);

  ebt_pkg::ebt_presc_s st_reg;
  ebt_pkg::ebt_presc_s st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.casc_d = cascade_in;
    // divider restarts with each enable so the first period is full
    st_next.div    = run_in ? st_reg.div + 10'h001 : 10'h000;
    case (sel_in)
      ebt_pkg::EBT_CKS_DIV1: begin
        st_next.tick = run_in;
      end
      ebt_pkg::EBT_CKS_DIV2: begin
        st_next.tick = run_in && ((st_reg.div & ebt_pkg::EBT_MASK_DIV2)
                                  == ebt_pkg::EBT_MASK_DIV2);
      end
      ebt_pkg::EBT_CKS_DIV4: begin
        st_next.tick = run_in && ((st_reg.div & ebt_pkg::EBT_MASK_DIV4)
                                  == ebt_pkg::EBT_MASK_DIV4);
      end
      ebt_pkg::EBT_CKS_DIV64: begin
        st_next.tick = run_in && ((st_reg.div & ebt_pkg::EBT_MASK_DIV64)
                                  == ebt_pkg::EBT_MASK_DIV64);
      end
      ebt_pkg::EBT_CKS_DIV1024: begin
        st_next.tick = run_in && ((st_reg.div & ebt_pkg::EBT_MASK_DIV1K)
                                  == ebt_pkg::EBT_MASK_DIV1K);
      end
      ebt_pkg::EBT_CKS_CASCADE: begin
        st_next.tick = run_in && cascade_in && !st_reg.casc_d;
      end
      default: begin
        // prohibited codes give no count clock
        st_next.tick = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;

endmodule : ebt_prescaler

// *** rtl/ebt_timer.sv ***
// Purpose: 8-bit timer with interval and pwm output modes
// Assumes: byte register port, read data one cycle after the strobe
// Notes:   status bits clear on read; counting freezes with ce_in low
`timescale 1ns/1ps

module ebt_timer (
  // clock, reset and clock enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // register port
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [7:0]  rd_data_out,
  // count source
  input  wire logic        cascaded_timer_output_in,
  // timer output
  output logic             pwm_output_pin_out,
  output logic             pwm_output_oe_out,
  // interrupts
  output logic             compare_match_interrupt_out,
  output logic             irq_out
);

  ebt_pkg::ebt_core_s st_reg;
  ebt_pkg::ebt_core_s st_next;

  logic                          tick;
  logic                          mode_ok;
  logic                          pwm_mode;
  logic                          period_hit;
  logic                          duty_hit;
  logic                          stat_clr;
  logic [ebt_pkg::EBT_STAT_W-1:0] stat_set;
  logic [ebt_pkg::EBT_STAT_W-1:0] stat;

  // count clock source
  ebt_prescaler u_presc (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .run_in     (st_reg.mode.count_enable_bit),
    .sel_in     (st_reg.mode.clock_select),
    .cascade_in (cascaded_timer_output_in),
    .tick_out   (tick)
  );

  // sticky status flags, one per event
  genvar gi;
  generate
    for (gi = 0; gi < ebt_pkg::EBT_STAT_W; gi++) begin : g_stat
      ebt_sticky u_flag (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .set_in   (stat_set[gi]),
        .clr_in   (stat_clr),
        .flag_out (stat[gi])
      );
    end
  endgenerate

  // mode decode
  always_comb begin
    pwm_mode = (st_reg.mode.operating_mode == ebt_pkg::EBT_MODE_PWM);
    // prohibited mode codes simply stall the counter
    mode_ok  = pwm_mode ||
               (st_reg.mode.operating_mode == ebt_pkg::EBT_MODE_INTERVAL);
  end

  // compare events
  always_comb begin
    period_hit = 1'b0;
    duty_hit   = 1'b0;
    if (st_reg.mode.count_enable_bit && tick && mode_ok) begin
      case (st_reg.cmp_sel)
        ebt_pkg::EBT_CMP_PERIOD: begin
          period_hit = (st_reg.count == st_reg.period);
        end
        ebt_pkg::EBT_CMP_DUTY: begin
          // duty is read live, so a rewrite while running takes effect
          duty_hit = pwm_mode && (st_reg.count == st_reg.duty);
        end
        default: begin
          period_hit = 1'b0;
        end
      endcase
    end
    stat_set                           = '0;
    stat_set[ebt_pkg::EBT_STAT_PERIOD] = period_hit;
    stat_set[ebt_pkg::EBT_STAT_DUTY]   = duty_hit;
  end

  // a read of the status register clears it; a set in that cycle wins
  always_comb begin
    stat_clr = rd_en_in && (addr_in == ebt_pkg::EBT_ADDR_STATUS);
  end

  // next state of the core
  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;

    // register writes
    if (wr_en_in) begin
      case (addr_in)
        ebt_pkg::EBT_ADDR_MODE: begin
          st_next.mode = ebt_pkg::ebt_mode_s'(wr_data_in);
        end
        ebt_pkg::EBT_ADDR_PERIOD: begin
          // no lockout while counting; software keeps off it
          st_next.period = wr_data_in;
        end
        ebt_pkg::EBT_ADDR_DUTY: begin
          st_next.duty = wr_data_in;
        end
        ebt_pkg::EBT_ADDR_MASK: begin
          st_next.mask = wr_data_in[ebt_pkg::EBT_STAT_W-1:0];
        end
        default: begin
          st_next.mask = st_reg.mask;
        end
      endcase
    end

    // register reads, data valid only in the following cycle
    st_next.rd_data = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        ebt_pkg::EBT_ADDR_MODE: begin
          st_next.rd_data = st_reg.mode;
        end
        ebt_pkg::EBT_ADDR_PERIOD: begin
          st_next.rd_data = st_reg.period;
        end
        ebt_pkg::EBT_ADDR_DUTY: begin
          st_next.rd_data = st_reg.duty;
        end
        ebt_pkg::EBT_ADDR_STATUS: begin
          st_next.rd_data = {6'h00, stat};
        end
        ebt_pkg::EBT_ADDR_MASK: begin
          st_next.rd_data = {6'h00, st_reg.mask};
        end
        ebt_pkg::EBT_ADDR_COUNT: begin
          st_next.rd_data = st_reg.count;
        end
        default: begin
          st_next.rd_data = 8'h00;
        end
      endcase
    end

    // counter and compare sequencing
    if (!st_reg.mode.count_enable_bit) begin
      // stopped: counter cleared, period compared first on restart
      st_next.count   = 8'h00;
      st_next.cmp_sel = ebt_pkg::EBT_CMP_PERIOD;
      st_next.active  = 1'b0;
    end else if (period_hit) begin
      st_next.count = 8'h00;
      st_next.pulse = 1'b1;
      if (pwm_mode) begin
        st_next.active  = 1'b1;
        st_next.cmp_sel = ebt_pkg::EBT_CMP_DUTY;
      end else begin
        // interval output toggles on each match, a square wave
        st_next.active  = ~st_reg.active;
        st_next.cmp_sel = ebt_pkg::EBT_CMP_PERIOD;
      end
    end else if (duty_hit) begin
      // no clear and no interrupt pulse here
      st_next.active  = 1'b0;
      st_next.cmp_sel = ebt_pkg::EBT_CMP_PERIOD;
      st_next.count   = st_reg.count + 8'h01;
    end else if (tick && mode_ok) begin
      // wraps past ffh if duty is not below period
      st_next.count = st_reg.count + 8'h01;
    end

    // output pin: active level is the inverse of the default level
    st_next.oe  = st_next.mode.output_pin_enable;
    st_next.pin = st_next.mode.output_pin_enable &
                  (st_next.active ^
                   st_next.mode.default_output_level);

    // level interrupt follows the flags one cycle late
    st_next.irq = |(stat & st_reg.mask);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg         <= '0;
      st_reg.mode    <= ebt_pkg::ebt_mode_s'(ebt_pkg::EBT_MODE_RST);
      st_reg.period  <= ebt_pkg::EBT_PERIOD_RST;
      st_reg.duty    <= ebt_pkg::EBT_DUTY_RST;
      st_reg.mask    <= ebt_pkg::EBT_MASK_RST;
      st_reg.cmp_sel <= ebt_pkg::EBT_CMP_PERIOD;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign rd_data_out                 = st_reg.rd_data;
  assign pwm_output_pin_out          = st_reg.pin;
  assign pwm_output_oe_out           = st_reg.oe;
  assign compare_match_interrupt_out = st_reg.pulse;
  assign irq_out                     = st_reg.irq;

endmodule : ebt_timer

// *** sim/ebt_timer_properties.sv ***
// Purpose: port-level assertions for the 8-bit pwm/interval timer
// Assumes: ce_in may drop; mode and mask are shadowed from bus writes
// Notes:   age_reg lets the output pipeline settle after a mode write
`timescale 1ns/1ps

module ebt_timer_properties (
  // clock and control
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  // register port
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  rd_data_out,
  // count source and outputs
  input wire logic        cascaded_timer_output_in,
  input wire logic        pwm_output_pin_out,
  input wire logic        pwm_output_oe_out,
  input wire logic        compare_match_interrupt_out,
  input wire logic        irq_out
);
  logic [7:0] mode_reg;
  logic [1:0] mask_reg;
  logic [1:0] age_reg;
  logic       wr_mode;
  logic       quiet;

  assign wr_mode = wr_en_in && ce_in && addr_in == ebt_pkg::EBT_ADDR_MODE;
  assign quiet   = age_reg == 2'h3 && !mode_reg[7];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg <= 8'h00;
      mask_reg <= 2'h0;
      age_reg  <= 2'h0;
    end else begin
      if (wr_mode)
        mode_reg <= wr_data_in;
      if (wr_en_in && ce_in && addr_in == ebt_pkg::EBT_ADDR_MASK)
        mask_reg <= wr_data_in[1:0];
      // saturate so old writes stop mattering
      if (wr_mode)
        age_reg <= 2'h0;
      else if (age_reg != 2'h3)
        age_reg <= age_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // a frozen cycle holds the last read data, so only judge live cycles
  AST_RD_IDLE: assert property (
    $past(ce_in) && !$past(rd_en_in) |-> rd_data_out == 8'h00)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (rd_en_in &&
    !(addr_in inside {[16'hff69:16'hff6e]}) |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  AST_CNT_OFF: assert property (
    quiet && rd_en_in && addr_in == ebt_pkg::EBT_ADDR_COUNT
    |=> rd_data_out == 8'h00) else $error("counter not held at zero");
  AST_NO_PULSE_OFF: assert property (
    quiet |-> !compare_match_interrupt_out)
    else $error("match pulse while disabled");
  AST_OE_COPY: assert property (
    age_reg == 2'h3 |-> pwm_output_oe_out == mode_reg[0])
    else $error("output enable differs from mode");
  AST_PIN_OFF: assert property (
    !pwm_output_oe_out |-> !pwm_output_pin_out)
    else $error("pin driven while disabled");
  AST_PIN_LEVEL: assert property (
    quiet |-> pwm_output_pin_out == (mode_reg[1] & mode_reg[0]))
    else $error("pin not at default level");
  AST_IRQ_SET: assert property (
    ce_in && compare_match_interrupt_out && mask_reg[0] |=> irq_out)
    else $error("unmasked match gave no irq");
  AST_IRQ_MASKED: assert property (
    mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !irq_out)
    else $error("irq with all sources masked");
endmodule : ebt_timer_properties

bind ebt_timer ebt_timer_properties chk_u (.clk_in, .rst_in, .ce_in,
  .addr_in, .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out,
  .cascaded_timer_output_in, .pwm_output_pin_out, .pwm_output_oe_out,
  .compare_match_interrupt_out, .irq_out);

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the 8-bit pwm/interval timer
// Assumes: ce_in dropped in one test only; cascade follows the cycle count
// Notes:   expected figures come from the values the bench writes
`timescale 1ns/1ps

module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdat = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        casc = 1'b0;
  logic [7:0]  rdat;
  logic        pin, oe, pulse, irq;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  v;
  logic [15:0] n;

  always #50 clk = ~clk;

  ebt_timer dut (.clk_in(clk), .rst_in(rst), .ce_in(ce), .addr_in(addr),
    .wr_data_in(wdat), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat),
    .cascaded_timer_output_in(casc), .pwm_output_pin_out(pin),
    .pwm_output_oe_out(oe), .compare_match_interrupt_out(pulse),
    .irq_out(irq));

  // one cascade rising edge every 6 cycles; cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    casc <= (cyc % 6) < 3;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask : rd_reg

  task automatic wait_pulse(input logic [15:0] lim, output logic [15:0] k);
    k = 16'h0;
    do begin
      tick();
      k++;
    end while (pulse !== 1'b1 && k < lim);
  endtask : wait_pulse

  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rd_reg(ebt_pkg::EBT_ADDR_MODE + 16'(i), v);
      chk("reset value", {8'h0, v}, 16'h0);
    end
    wr_reg(ebt_pkg::EBT_ADDR_PERIOD, 8'ha5);
    wr_reg(ebt_pkg::EBT_ADDR_MASK, 8'hff);
    wr_reg(16'hff70, 8'h77);
    rd_reg(ebt_pkg::EBT_ADDR_PERIOD, v);
    chk("period", {8'h0, v}, 16'ha5);
    rd_reg(ebt_pkg::EBT_ADDR_MASK, v);
    chk("mask", {8'h0, v}, 16'h3);
    rd_reg(16'hff70, v);
    chk("unmapped", {8'h0, v}, 16'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_clk();
    logic [15:0] dv [6] = '{16'd1, 16'd2, 16'd4, 16'd64, 16'd1024, 16'd6};
    wr_reg(ebt_pkg::EBT_ADDR_PERIOD, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h00);
      wr_reg(ebt_pkg::EBT_ADDR_MODE, {1'b1, i[2:0], 4'h0});
      wait_pulse(16'd3000, n);
      wait_pulse(16'd3000, n);
      chk("spacing", n, dv[i] * 16'd2);
    end
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'he0);
    wait_pulse(16'd40, n);
    chk("bad clock code", {15'h0, pulse}, 16'h0);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h84);
    wait_pulse(16'd40, n);
    chk("bad mode code", {15'h0, pulse}, 16'h0);
    $display("test clock done");
  endtask : t_clk

  task automatic pwm(input logic [7:0] md, du, input logic [15:0] hi);
    logic [15:0] h;
    logic [15:0] p;
    wr_reg(ebt_pkg::EBT_ADDR_DUTY, du);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, md);
    wait_pulse(16'd50, n);
    wait_pulse(16'd50, n);
    h = 16'h0;
    p = 16'h0;
    repeat (4) begin
      h += {15'h0, pin ^ md[1]};
      p += {15'h0, pulse};
      tick();
    end
    chk("active time", h, hi);
    chk("pulses", p, 16'h1);
    chk("period", n, 16'h4);
  endtask : pwm

  task automatic t_pwm();
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h00);
    wr_reg(ebt_pkg::EBT_ADDR_PERIOD, 8'h03);
    pwm(8'h89, 8'h01, 16'h2);
    pwm(8'h89, 8'h02, 16'h3);
    rd_reg(ebt_pkg::EBT_ADDR_STATUS, v);
    chk("pwm status", {8'h0, v}, 16'h3);
    // a smaller duty written past its count would wait for the wrap
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h00);
    pwm(8'h8b, 8'h00, 16'h1);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h00);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_irq();
    wr_reg(ebt_pkg::EBT_ADDR_MASK, 8'h01);
    wr_reg(ebt_pkg::EBT_ADDR_PERIOD, 8'h01);
    rd_reg(ebt_pkg::EBT_ADDR_STATUS, v);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h80);
    wait_pulse(16'd50, n);
    tick();
    chk("irq raised", {15'h0, irq}, 16'h1);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h03);
    tick();
    rd_reg(ebt_pkg::EBT_ADDR_STATUS, v);
    chk("status", {8'h0, v}, 16'h1);
    tick();
    tick();
    chk("irq cleared", {15'h0, irq}, 16'h0);
    rd_reg(ebt_pkg::EBT_ADDR_COUNT, v);
    chk("count held", {8'h0, v}, 16'h0);
    chk("default level", {14'h0, oe, pin}, 16'h3);
    wr_reg(ebt_pkg::EBT_ADDR_MASK, 8'h00);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h80);
    wait_pulse(16'd50, n);
    tick();
    chk("irq masked", {15'h0, irq}, 16'h0);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h00);
    $display("test irq done");
  endtask : t_irq

  task automatic t_ce();
    wr_reg(ebt_pkg::EBT_ADDR_PERIOD, 8'hff);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h80);
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    // the tick made before the freeze only lands after it
    rd_reg(ebt_pkg::EBT_ADDR_COUNT, v);
    chk("frozen count", {8'h0, v}, 16'h1);
    wr_reg(ebt_pkg::EBT_ADDR_MODE, 8'h00);
    $display("test ce done");
  endtask : t_ce

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_clk();
    t_pwm();
    t_irq();
    t_ce();
    tally_and_finish();
  end
endmodule : tb_top
